// ===== logic/gain_ramp.sv
`timescale 1ns/1ps
`include "gsw_defs.svh"
module gain_ramp (
   // Ramp operands
   gain_ramp_if.ramp rif
);
   import gsw_pkg::*;
   genvar i;
   generate
      for (i = 0; i < 7; i++) begin : g_mix
         logic signed [16:0] diff;
         logic signed [28:0] prod;
         logic signed [17:0] sum;
         assign diff = $signed({1'b0, rif.to_v[i]}) - $signed({1'b0, rif.from_v[i]});
         assign prod = diff * $signed({1'b0, rif.frac});  // see (RQ14)
         assign sum  = $signed({2'b00, rif.from_v[i]}) + 18'(prod >>> `GSW_FRAC_BITS);
         assign rif.mix_v[i] = sum[15:0];
      end
   endgenerate
endmodule // gain_ramp

// ===== logic/gain_ramp_if.sv
`timescale 1ns/1ps
interface gain_ramp_if;
   import gsw_pkg::*;
   gain_set_t   from_v;
   gain_set_t   to_v;
   gain_set_t   mix_v;
   logic [10:0] frac;
   modport ctrl (output from_v, output to_v, output frac, input mix_v);
   modport ramp (input from_v, input to_v, input frac, output mix_v);
endinterface

// ===== logic/gsw_defs.svh
// Notes on behaviour
// (RQ1) Motor swap with compensation on raises warning
// (RQ2) Reset, disable or suppress clears the warning
// (RQ3) Detect digit 0 detects; applied on restart
// (RQ4) Type digit 0 manual, 2 automatic, immediate
// (RQ5) Host never writes reserved type value 1
// (RQ6) Automatic only in position; manual in all
// (RQ7) Each bank holds seven values, swapped together
// (RQ8) Model following values never switch automatically
// (RQ9) Model following switches only stopped, no reference
// (RQ10) Select bit 0 bank 1, 1 bank 2
// (RQ11) Automatic mode selects bank from internal conditions
// (RQ12) Condition A: wait then ramp, times per direction
// (RQ13) Condition code table; even/odd outside position
// (RQ14) Wait out delay, then ramp gains linearly
// (RQ15) Manual change applied in the receiving cycle
`ifndef GSW_DEFS_SVH
`define GSW_DEFS_SVH
`define GSW_CLK_NS          40
`define GSW_UNIT_NS         1000000
`define GSW_FRAC_BITS       10
`define GSW_FRAC_ONE        11'h400
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define GSW_A_GSEL          8'h00
`define GSW_A_RIPPLE        8'h04
`define GSW_A_WAIT1         8'h08
`define GSW_A_WAIT2         8'h0c
`define GSW_A_RAMP1         8'h10
`define GSW_A_RAMP2         8'h14
`define GSW_A_CTRL          8'h18
`define GSW_A_STATUS        8'h1c
`define GSW_A_MASK          8'h20
`define GSW_A_STATE         8'h24
`define GSW_A_BANK1         8'h40
`define GSW_A_BANK2         8'h60
// ----------------------------------------------------------------
// Field values
// ----------------------------------------------------------------
`define GSW_TYPE_AUTO1      4'h2
`define GSW_MODE_POSITION   2'h0
`define GSW_CTRL_RESTART    0
`define GSW_CTRL_COMP_RST   1
`define GSW_ST_WARN         0
`define GSW_ST_SWITCHED     1
`define GSW_MF_GAIN         4
`define GSW_MF_CORR         5
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GSW_DEF_GSEL        8'h00
`define GSW_DEF_RIPPLE      12'h000
`define GSW_DEF_TIME        16'h0000
`define GSW_DEF_BANK1       {16'h0064, 16'h03e8, 16'h01f4, 16'h0064, 16'h0190, 16'h07d0, 16'h0190}
`define GSW_DEF_BANK2       {16'h0064, 16'h03e8, 16'h01f4, 16'h0064, 16'h0190, 16'h07d0, 16'h0190}
`endif

// ===== logic/gsw_pkg.sv
package gsw_pkg;
   typedef logic [6:0][15:0] gain_set_t;
   typedef enum logic [2:0] {
      ST_HOLD = 3'b001,
      ST_WAIT = 3'b010,
      ST_RAMP = 3'b100
   } sw_state_t;
   typedef struct packed {
      logic [11:0] param_r;
      logic        act_en_r;
      logic        act_det_r;
      logic        warn_r;
   } ripple_state_t;
   typedef struct packed {
      logic [7:0]     gsel_r;
      logic [11:0]    ripple_r;
      logic [15:0]    wait1_r;
      logic [15:0]    wait2_r;
      logic [15:0]    ramp1_r;
      logic [15:0]    ramp2_r;
      logic [1:0]     status_r;
      logic [1:0]     mask_r;
      gain_set_t      bank1_r;
      gain_set_t      bank2_r;
      gain_set_t      gains_r;
      logic           sel_r;
      logic           mf_bank_r;
      sw_state_t      state_r;
      logic [15:0]    cnt_r;
      logic [15:0]    div_r;
      logic [31:0]    rdata_r;
   } gsw_state_t;
endpackage

// ===== logic/ripple_warn.sv
`timescale 1ns/1ps
`include "gsw_defs.svh"
module ripple_warn (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        srst_in,
   // Events
   input  wire logic        motor_replaced_in,
   input  wire logic        comp_reset_in,
   input  wire logic        restart_in,
   input  wire logic        param_wr_in,
   input  wire logic [11:0] param_in,
   // Warning
   output logic             warn_out,
   output logic             warn_set_out
);
   import gsw_pkg::*;
   ripple_state_t s_r;
   ripple_state_t s_nxt;
   logic          set_w;
   logic          clr_w;

   always_comb begin
      s_nxt = s_r;
      if (param_wr_in) begin
         s_nxt.param_r = param_in;
      end
      // Setup digits only arm detection after a restart
      if (restart_in) begin
         s_nxt.act_en_r  = s_nxt.param_r[0];   // see (RQ3)
         s_nxt.act_det_r = ~s_nxt.param_r[4];  // see (RQ3)
      end
      set_w = motor_replaced_in & s_r.act_en_r & s_r.act_det_r;  // see (RQ1)
      clr_w = comp_reset_in | (param_wr_in & (param_in[3:0] == 4'h0 | param_in[7:4] == 4'h1));  // see (RQ2)
      // A swap seen in the clearing cycle still raises the warning
      if (clr_w) begin
         s_nxt.warn_r = 1'b0;
      end
      if (set_w) begin
         s_nxt.warn_r = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         s_r <= '{param_r: `GSW_DEF_RIPPLE, act_en_r: 1'b0, act_det_r: 1'b1, warn_r: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign warn_out     = s_r.warn_r;
   assign warn_set_out = set_w;
endmodule // ripple_warn

// ===== logic/servo_gain_set_switching.sv
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
`include "gsw_defs.svh"
module servo_gain_set_switching #(
   parameter int CYC_PER_UNIT = `GSW_UNIT_NS / `GSW_CLK_NS
) (
   // Clock and reset
   input  wire logic         clk_in,
   input  wire logic         srst_in,
   // Register port
   input  wire logic [7:0]   addr_in,
   input  wire logic [31:0]  wdata_in,
   input  wire logic         wr_in,
   input  wire logic         rd_in,
   output logic [31:0]       rdata_out,
   // Servo command and control loop status
   input  wire logic         gain_bank_select_in,
   input  wire logic [1:0]   control_mode_in,
   input  wire logic         positioning_done_in,
   input  wire logic         near_in,
   input  wire logic         ref_filter_zero_in,
   input  wire logic         ref_input_on_in,
   input  wire logic         motor_stopped_in,
   input  wire logic         motor_replaced_in,
   // Active gains and status
   output gsw_pkg::gain_set_t gains_out,
   output logic              active_bank_out,
   output logic              ripple_warn_out,
   output logic              irq_out
);
   import gsw_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic cond_a(input logic [3:0] code, input logic positioning_done_signal, input logic nr,
                                   input logic fz, input logic ron);
      case (code)
         4'h0:    cond_a = positioning_done_signal;        // see (RQ13)
         4'h1:    cond_a = ~positioning_done_signal;
         4'h2:    cond_a = nr;
         4'h3:    cond_a = ~nr;
         4'h4:    cond_a = fz & ~ron;
         4'h5:    cond_a = ron;
         default: cond_a = 1'b0;
      endcase
   endfunction

   function automatic logic is_addr(input logic [7:0] a, input logic [7:0] base);
      is_addr = (a == base);
   endfunction

   function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
      in_bank = (a >= base) && (a < base + 8'h1c) && (a[1:0] == 2'b00);
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   gsw_state_t   s_r;
   gsw_state_t   s_nxt;
   gain_ramp_if  rif ();
   logic         warn_w;
   logic         warn_set_w;
   logic         restart_w;
   logic         comp_rst_w;
   logic         ripple_wr_w;
   logic         tick_w;
   logic         auto_w;
   logic         cond_w;
   logic         target_w;
   logic         switched_w;
   logic [15:0]  wait_w;
   logic [15:0]  ramp_w;
   logic [25:0]  quot_w;
   logic [2:0]   bidx_w;
   logic [31:0]  rd_w;
   logic [1:0]   status_clr_w;

   assign restart_w   = wr_in & is_addr(addr_in, `GSW_A_CTRL) & wdata_in[`GSW_CTRL_RESTART];
   assign comp_rst_w  = wr_in & is_addr(addr_in, `GSW_A_CTRL) & wdata_in[`GSW_CTRL_COMP_RST];
   assign ripple_wr_w = wr_in & is_addr(addr_in, `GSW_A_RIPPLE);

   ripple_warn u_ripple (
      .clk_in            (clk_in),
      .srst_in           (srst_in),
      .motor_replaced_in (motor_replaced_in),
      .comp_reset_in     (comp_rst_w),
      .restart_in        (restart_w),
      .param_wr_in       (ripple_wr_w),
      .param_in          (wdata_in[11:0]),
      .warn_out          (warn_w),
      .warn_set_out      (warn_set_w)
   );

   gain_ramp u_ramp (
      .rif (rif.ramp)
   );

   // ----------------------------------------------------------------
   // Interpolation operands
   // ----------------------------------------------------------------
   // One shared divider: every value shares the same ramp fraction
   assign wait_w = s_r.sel_r ? s_r.wait2_r : s_r.wait1_r;   // see (RQ12)
   assign ramp_w = s_r.sel_r ? s_r.ramp2_r : s_r.ramp1_r;   // see (RQ12)
   assign quot_w = (ramp_w == 16'h0000) ? 26'(`GSW_FRAC_ONE) : ({s_r.cnt_r, 10'h000} / 26'(ramp_w));
   assign rif.frac   = (quot_w > 26'(`GSW_FRAC_ONE)) ? `GSW_FRAC_ONE : quot_w[10:0];
   assign rif.from_v = s_r.sel_r ? s_r.bank2_r : s_r.bank1_r;
   assign rif.to_v   = s_r.sel_r ? s_r.bank1_r : s_r.bank2_r;

   assign tick_w = (s_r.div_r == 16'(CYC_PER_UNIT - 1));
   assign auto_w = (s_r.gsel_r[3:0] == `GSW_TYPE_AUTO1);   // see (RQ4)
   assign cond_w = cond_a(s_r.gsel_r[7:4], positioning_done_in, near_in, ref_filter_zero_in, ref_input_on_in);
   assign target_w = cond_w;   // see (RQ11)
   assign bidx_w = 3'((addr_in[4:0]) >> 2);

   // ----------------------------------------------------------------
   // Register read
   // ----------------------------------------------------------------
   always_comb begin
      rd_w = 32'h0000_0000;
      if (is_addr(addr_in, `GSW_A_GSEL)) begin
         rd_w = {24'h00_0000, s_r.gsel_r};
      end else if (is_addr(addr_in, `GSW_A_RIPPLE)) begin
         rd_w = {20'h0_0000, s_r.ripple_r};
      end else if (is_addr(addr_in, `GSW_A_WAIT1)) begin
         rd_w = {16'h0000, s_r.wait1_r};
      end else if (is_addr(addr_in, `GSW_A_WAIT2)) begin
         rd_w = {16'h0000, s_r.wait2_r};
      end else if (is_addr(addr_in, `GSW_A_RAMP1)) begin
         rd_w = {16'h0000, s_r.ramp1_r};
      end else if (is_addr(addr_in, `GSW_A_RAMP2)) begin
         rd_w = {16'h0000, s_r.ramp2_r};
      end else if (is_addr(addr_in, `GSW_A_STATUS)) begin
         rd_w = {30'h0000_0000, s_r.status_r};
      end else if (is_addr(addr_in, `GSW_A_MASK)) begin
         rd_w = {30'h0000_0000, s_r.mask_r};
      end else if (is_addr(addr_in, `GSW_A_STATE)) begin
         rd_w = {26'h000_0000, s_r.state_r, warn_w, s_r.mf_bank_r, s_r.sel_r};
      end else if (in_bank(addr_in, `GSW_A_BANK1)) begin
         rd_w = {16'h0000, s_r.bank1_r[bidx_w]};
      end else if (in_bank(addr_in, `GSW_A_BANK2)) begin
         rd_w = {16'h0000, s_r.bank2_r[bidx_w]};
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      switched_w = 1'b0;
      s_nxt.rdata_r = rd_in ? rd_w : 32'h0000_0000;

      if (wr_in) begin
         if (is_addr(addr_in, `GSW_A_GSEL)) begin
            s_nxt.gsel_r = wdata_in[7:0];
         end
         if (ripple_wr_w) begin
            s_nxt.ripple_r = wdata_in[11:0];
         end
         if (is_addr(addr_in, `GSW_A_WAIT1)) begin
            s_nxt.wait1_r = wdata_in[15:0];
         end
         if (is_addr(addr_in, `GSW_A_WAIT2)) begin
            s_nxt.wait2_r = wdata_in[15:0];
         end
         if (is_addr(addr_in, `GSW_A_RAMP1)) begin
            s_nxt.ramp1_r = wdata_in[15:0];
         end
         if (is_addr(addr_in, `GSW_A_RAMP2)) begin
            s_nxt.ramp2_r = wdata_in[15:0];
         end
         if (is_addr(addr_in, `GSW_A_MASK)) begin
            s_nxt.mask_r = wdata_in[1:0];
         end
         if (in_bank(addr_in, `GSW_A_BANK1)) begin
            s_nxt.bank1_r[bidx_w] = wdata_in[15:0];   // see (RQ7)
         end
         if (in_bank(addr_in, `GSW_A_BANK2)) begin
            s_nxt.bank2_r[bidx_w] = wdata_in[15:0];   // see (RQ7)
         end
      end

      // Unit divider runs free so a wait starts within one unit
      s_nxt.div_r = tick_w ? 16'h0000 : s_r.div_r + 16'h0001;

      if (!auto_w) begin
         // Manual: selection bit applied in the same cycle it arrives
         s_nxt.state_r = ST_HOLD;
         s_nxt.cnt_r   = 16'h0000;
         s_nxt.sel_r   = gain_bank_select_in;   // see (RQ10) see (RQ15) see (RQ6)
         if (!ref_input_on_in && motor_stopped_in) begin
            s_nxt.mf_bank_r = gain_bank_select_in;   // see (RQ9)
         end
      end else if (control_mode_in != `GSW_MODE_POSITION) begin
         s_nxt.state_r = ST_HOLD;
         s_nxt.cnt_r   = 16'h0000;
         s_nxt.sel_r   = s_r.gsel_r[4];   // see (RQ13) see (RQ6)
      end else begin
         case (s_r.state_r)
            ST_HOLD: begin
               if (target_w != s_r.sel_r) begin
                  s_nxt.state_r = ST_WAIT;
                  s_nxt.cnt_r   = 16'h0000;
               end
            end
            ST_WAIT: begin
               if (target_w == s_r.sel_r) begin
                  s_nxt.state_r = ST_HOLD;
               end else if (s_r.cnt_r >= wait_w) begin
                  s_nxt.state_r = ST_RAMP;   // see (RQ14)
                  s_nxt.cnt_r   = 16'h0000;
               end else if (tick_w) begin
                  s_nxt.cnt_r = s_r.cnt_r + 16'h0001;
               end
            end
            ST_RAMP: begin
               // A ramp once begun runs to its end unless the mode leaves automatic position control
               if (s_r.cnt_r >= ramp_w) begin
                  s_nxt.state_r = ST_HOLD;
                  s_nxt.sel_r   = ~s_r.sel_r;   // see (RQ12)
                  s_nxt.cnt_r   = 16'h0000;
                  switched_w    = 1'b1;
               end else if (tick_w) begin
                  s_nxt.cnt_r = s_r.cnt_r + 16'h0001;
               end
            end
            default: begin
               s_nxt.state_r = ST_HOLD;
               s_nxt.cnt_r   = 16'h0000;
            end
         endcase
      end

      // Active gains
      for (int i = 0; i < 7; i++) begin
         if (i == `GSW_MF_GAIN || i == `GSW_MF_CORR) begin
            s_nxt.gains_r[i] = s_nxt.mf_bank_r ? s_nxt.bank2_r[i] : s_nxt.bank1_r[i];   // see (RQ8)
         end else if (s_r.state_r == ST_RAMP && s_nxt.state_r == ST_RAMP) begin
            s_nxt.gains_r[i] = rif.mix_v[i];   // see (RQ14)
         end else begin
            s_nxt.gains_r[i] = s_nxt.sel_r ? s_nxt.bank2_r[i] : s_nxt.bank1_r[i];   // see (RQ7)
         end
      end

      // Status: read clears, a new event in the same cycle wins
      status_clr_w = (rd_in && is_addr(addr_in, `GSW_A_STATUS)) ? 2'b11 : 2'b00;
      s_nxt.status_r = (s_r.status_r & ~status_clr_w) | {switched_w, warn_set_w};
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         s_r <= '{gsel_r: `GSW_DEF_GSEL, ripple_r: `GSW_DEF_RIPPLE, wait1_r: `GSW_DEF_TIME,
                  wait2_r: `GSW_DEF_TIME, ramp1_r: `GSW_DEF_TIME, ramp2_r: `GSW_DEF_TIME,
                  status_r: 2'b00, mask_r: 2'b00, bank1_r: `GSW_DEF_BANK1, bank2_r: `GSW_DEF_BANK2,
                  gains_r: `GSW_DEF_BANK1, sel_r: 1'b0, mf_bank_r: 1'b0, state_r: ST_HOLD,
                  cnt_r: 16'h0000, div_r: 16'h0000, rdata_r: 32'h0000_0000};
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign rdata_out       = s_r.rdata_r;
   assign gains_out       = s_r.gains_r;
   assign active_bank_out = s_r.sel_r;
   assign ripple_warn_out = warn_w;
   assign irq_out         = |(s_r.status_r & s_r.mask_r);
endmodule // servo_gain_set_switching

// ===== verif/gsw_assertions.sv
`timescale 1ns/1ps
module gsw_assertions #(
   parameter int CYC_PER_UNIT = 4
) (
   // Clock and reset
   input  wire logic               clk_in,
   input  wire logic               srst_in,
   // Register port
   input  wire logic [7:0]         addr_in,
   input  wire logic [31:0]        wdata_in,
   input  wire logic               wr_in,
   input  wire logic               rd_in,
   input  wire logic [31:0]        rdata_out,
   // Servo command and status
   input  wire logic               gain_bank_select_in,
   input  wire logic [1:0]         control_mode_in,
   input  wire logic               positioning_done_in,
   input  wire logic               near_in,
   input  wire logic               ref_filter_zero_in,
   input  wire logic               ref_input_on_in,
   input  wire logic               motor_stopped_in,
   input  wire logic               motor_replaced_in,
   // Outputs
   input  wire gsw_pkg::gain_set_t gains_out,
   input  wire logic               active_bank_out,
   input  wire logic               ripple_warn_out,
   input  wire logic               irq_out
);
   import gsw_pkg::*;
   // ----
   // Shadow of the registers that steer the rules
   // ----
   localparam gain_set_t DEF = {16'h0064, 16'h03e8, 16'h01f4, 16'h0064, 16'h0190, 16'h07d0, 16'h0190};
   logic [7:0]  g_r;
   logic [11:0] p_r;
   logic        on_r;
   logic        clr_r;
   logic        mf_ok;
   assign mf_ok = motor_stopped_in && !ref_input_on_in && g_r[3:0] != 4'h2;
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         g_r   <= 8'h00;
         p_r   <= 12'h000;
         on_r  <= 1'b0;
         clr_r <= 1'b0;
      end else begin
         if (wr_in && addr_in == 8'h00) begin
            g_r <= wdata_in[7:0];
         end
         if (wr_in && addr_in == 8'h04) begin
            p_r <= wdata_in[11:0];
         end
         // Only a restart moves the parameter into the live copy
         if (wr_in && addr_in == 8'h18 && wdata_in[0]) begin
            on_r <= p_r[3:0] == 4'h1 && p_r[7:4] == 4'h0;
         end
         clr_r <= wr_in && (addr_in == 8'h04 || (addr_in == 8'h18 && wdata_in[1]));
      end
   end
   // ----
   // Properties
   // ----
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);
   reset_vals_a: assert property (disable iff (1'b0) srst_in |=> gains_out == DEF && !active_bank_out
      && !ripple_warn_out && !irq_out && rdata_out == 32'h0) else $error("Outputs not at reset values");
   rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
      else $error("Read data outside the answer cycle");
   warn_rise_a: assert property ($rose(ripple_warn_out) |-> $past(motor_replaced_in))
      else $error("Warning rose without a motor swap");
   warn_set_a: assert property (motor_replaced_in && on_r |=> ripple_warn_out)
      else $error("Motor swap not flagged");
   warn_suppr_a: assert property (motor_replaced_in && !on_r && !ripple_warn_out |=> !ripple_warn_out)
      else $error("Warning raised while detection is off");
   warn_clear_a: assert property ($fell(ripple_warn_out) |-> clr_r || $past(clr_r))
      else $error("Warning cleared without a clearing write");
   manual_bank_a: assert property (g_r[3:0] != 4'h2 && !wr_in |=>
      active_bank_out == $past(gain_bank_select_in)) else $error("Manual bank not applied");
   mf_hold_a: assert property ($changed(gains_out[4]) && !$past(wr_in) && !$past(wr_in, 2)
      |-> $past(mf_ok)) else $error("Model following gain switched wrongly");
   auto_other_a: assert property (g_r[3:0] == 4'h2 && control_mode_in != 2'h0 && g_r[7:4] <= 4'h5
      && !wr_in |=> active_bank_out == $past(g_r[4])) else $error("Bank outside position control wrong");
   cover property ($rose(active_bank_out) && g_r[3:0] == 4'h2);
   cover property ($rose(ripple_warn_out));
   cover property ($fell(irq_out));
endmodule // gsw_assertions

bind servo_gain_set_switching gsw_assertions #(.CYC_PER_UNIT(CYC_PER_UNIT)) i_chk (
   .clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
   .rd_in(rd_in), .rdata_out(rdata_out), .gain_bank_select_in(gain_bank_select_in),
   .control_mode_in(control_mode_in), .positioning_done_in(positioning_done_in), .near_in(near_in),
   .ref_filter_zero_in(ref_filter_zero_in), .ref_input_on_in(ref_input_on_in),
   .motor_stopped_in(motor_stopped_in), .motor_replaced_in(motor_replaced_in), .gains_out(gains_out),
   .active_bank_out(active_bank_out), .ripple_warn_out(ripple_warn_out), .irq_out(irq_out));

// ===== verif/host_cmd.sv
`timescale 1ns/1ps
module host_cmd (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       srst_in,
   // Requested command
   input  wire logic       sel_req_in,
   input  wire logic [1:0] mode_req_in,
   // Servo command word fields
   output logic            gain_bank_select_out,
   output logic [1:0]      control_mode_out
);
   // ----
   // Command word, refreshed once per cycle
   // ----
   // A real host sends whole words, so the fields land one cycle late
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         gain_bank_select_out <= 1'b0;
         control_mode_out     <= 2'h0;
      end else begin
         gain_bank_select_out <= sel_req_in;
         control_mode_out     <= mode_req_in;
      end
   end
endmodule // host_cmd

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
   import gsw_pkg::*;
   // ----
   // Signals
   // ----
   typedef struct packed {
      logic       s;
      logic [1:0] m;
      logic       st;
      logic       r;
      logic       b;
      logic       mf;
   } row_t;
   logic        clk_in   = 1'b0;
   logic        srst_in  = 1'b1;
   logic [7:0]  addr_in  = 8'h00;
   logic [31:0] wdata_in = 32'h0;
   logic        wr_in    = 1'b0;
   logic        rd_in    = 1'b0;
   logic        sel_q    = 1'b0;
   logic [1:0]  mode_q   = 2'h0;
   logic        done     = 1'b0;
   logic        ron      = 1'b0;
   logic        stop     = 1'b1;
   logic        mrep     = 1'b0;
   logic        sel;
   logic [1:0]  mode;
   logic [31:0] rdata_out;
   gain_set_t   gains_out;
   logic        bank;
   logic        warn;
   logic        irq;
   logic        mid;
   int          errors = 0;
   int          samples_checked = 0;
   int          n;
   row_t        rows [6] = '{7'h4b, 7'h11, 7'h6f, 7'h3d, 7'h08, 7'h56};
   always #20 clk_in = ~clk_in;
   host_cmd i_host (.clk_in(clk_in), .srst_in(srst_in), .sel_req_in(sel_q), .mode_req_in(mode_q),
      .gain_bank_select_out(sel), .control_mode_out(mode));
   // Short time unit keeps the waits and ramps to a few dozen cycles
   servo_gain_set_switching #(.CYC_PER_UNIT(4)) i_dut (.clk_in(clk_in), .srst_in(srst_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .gain_bank_select_in(sel), .control_mode_in(mode), .positioning_done_in(done), .near_in(done),
      .ref_filter_zero_in(1'b0), .ref_input_on_in(ron), .motor_stopped_in(stop), .motor_replaced_in(mrep),
      .gains_out(gains_out), .active_bank_out(bank), .ripple_warn_out(warn), .irq_out(irq));
   // ----
   // Tasks
   // ----
   function automatic gain_set_t expg(input logic b, input logic m);
      for (int i = 0; i < 7; i++) begin
         expg[i] = 16'(i) + ((((i == 4) || (i == 5)) ? m : b) ? 16'h0100 : 16'h0010);
      end
   endfunction
   task automatic chk(input logic [111:0] got, input logic [111:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_in);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      wr_in    <= 1'b1;
      addr_in  <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_in);
      rd_in   <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      chk(112'(rdata_out), 112'(e));
   endtask
   task automatic rp(input logic e);
      @(posedge clk_in);
      mrep <= 1'b1;
      @(posedge clk_in);
      mrep <= 1'b0;
      cyc(2);
      chk(112'(warn), 112'(e));
   endtask
   task automatic wait_bank(input logic b, input int lo, input int hi);
      n   = 0;
      mid = 1'b0;
      while (bank !== b && n < 100) begin
         cyc(1);
         n++;
         if (gains_out[2] > 16'h0012 && gains_out[2] < 16'h0102) begin
            mid = 1'b1;
         end
      end
      chk(112'({n >= lo && n <= hi, mid}), 112'h3);
   endtask
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ----
   // Tests
   // ----
   initial begin
      repeat (4000) @(posedge clk_in);
      errors++;
      $display("BAD %0t watchdog expired", $time);
      complete_run();
   end
   initial begin
      repeat (6) @(posedge clk_in);
      srst_in <= 1'b0;
      rd(8'hfc, 32'h0);
      rd(8'h00, 32'h0);
      rd(8'h44, 32'h7d0);
      for (int i = 0; i < 7; i++) begin
         wr(8'(8'h40 + 4 * i), 32'(16'h0010 + i));
         wr(8'(8'h60 + 4 * i), 32'(16'h0100 + i));
      end
      foreach (rows[k]) begin
         @(posedge clk_in);
         sel_q  <= rows[k].s;
         mode_q <= rows[k].m;
         stop   <= rows[k].st;
         ron    <= rows[k].r;
         cyc(3);
         chk(112'(bank), 112'(rows[k].b));
         chk(gains_out, expg(rows[k].b, rows[k].mf));
      end
      $display("Manual rows done");
      wr(8'h20, 32'h3);
      // Select bit stays high from the last row and must be ignored
      for (int c = 0; c < 6; c++) begin
         wr(8'h00, 32'(c * 16 + 2));
         cyc(2);
         chk(gains_out, expg(c[0], 1'b0));
      end
      wr(8'h00, 32'h2);
      wr(8'h08, 32'h2);
      wr(8'h10, 32'h4);
      wr(8'h0c, 32'h1);
      wr(8'h14, 32'h2);
      @(posedge clk_in);
      mode_q <= 2'h0;
      cyc(3);
      chk(112'(bank), 112'h0);
      @(posedge clk_in);
      done <= 1'b1;
      wait_bank(1'b1, 16, 28);
      chk(gains_out, expg(1'b1, 1'b0));
      rd(8'h24, 32'h9);
      chk(112'(irq), 112'h1);
      rd(8'h1c, 32'h2);
      rd(8'h1c, 32'h0);
      chk(112'(irq), 112'h0);
      wr(8'h00, 32'h32);
      wait_bank(1'b0, 4, 16);
      chk(gains_out, expg(1'b0, 1'b0));
      rd(8'h1c, 32'h2);
      $display("Automatic switching done");
      rp(1'b0);
      wr(8'h04, 32'h1);
      rp(1'b0);
      wr(8'h18, 32'h1);
      rp(1'b1);
      chk(112'(irq), 112'h1);
      rd(8'h1c, 32'h1);
      wr(8'h18, 32'h2);
      rp(1'b1);
      wr(8'h04, 32'h11);
      cyc(2);
      chk(112'(warn), 112'h0);
      wr(8'h18, 32'h1);
      rp(1'b0);
      wr(8'h04, 32'h1);
      wr(8'h18, 32'h1);
      rp(1'b1);
      wr(8'h04, 32'h0);
      cyc(2);
      chk(112'(warn), 112'h0);
      $display("Ripple warning done");
      @(posedge clk_in);
      srst_in <= 1'b1;
      sel_q   <= 1'b0;
      repeat (3) @(posedge clk_in);
      srst_in <= 1'b0;
      #1;
      chk(gains_out, {16'h0064, 16'h03e8, 16'h01f4, 16'h0064, 16'h0190, 16'h07d0, 16'h0190});
      chk(112'({bank, warn, irq}), 112'h0);
      rd(8'h60, 32'h190);
      rd(8'h00, 32'h0);
      $display("Second reset done");
      complete_run();
   end
endmodule // tb
